/* hdl/cpu_bit_branch_control_ops.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bit_branch_control_ops (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// Decoded instruction stream
	input  wire logic        instr_valid_in,
	input  wire logic [15:0] instr_word_in,
	input  wire logic [31:0] instr_ext_in,
	input  wire logic [1:0]  instr_len_in,
	input  wire logic [7:0]  reg_byte_in,
	output logic             instr_ready_out,
	// General register side
	input  wire logic [15:0] count_word_in,
	input  wire logic [23:0] src_ptr_in,
	input  wire logic [23:0] dst_ptr_in,
	output logic             reg_wr_out,
	output logic [3:0]       reg_wr_sel_out,
	output logic [7:0]       reg_wr_data_out,
	output logic [15:0]      count_word_out,
	output logic [23:0]      src_ptr_out,
	output logic [23:0]      dst_ptr_out,
	output logic             copy_done_out,
	// Memory bus
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic [1:0]       mem_size_out,
	output logic [23:0]      mem_addr_out,
	output logic [31:0]      mem_wdata_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	// Wake from power-down
	input  wire logic        wake_in,
	// Status
	output logic [23:0]      pc_out,
	output logic [7:0]       ccr_out,
	output logic [7:0]       exr_out,
	output logic [23:0]      sp_out,
	output logic             sleep_out,
	output logic             branch_taken_out,
	output logic             trap_out
);
	import cpu_ops_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	state_e      state_reg,   state_next;
	logic [15:0] iw_reg,      iw_next;
	logic [31:0] ext_reg,     ext_next;
	logic [23:0] pc_reg,      pc_next;
	logic [23:0] sp_reg,      sp_next;
	logic [7:0]  ccr_reg,     ccr_next;
	logic [7:0]  exr_reg,     exr_next;
	logic [15:0] cnt_reg,     cnt_next;
	logic [23:0] src_reg,     src_next;
	logic [23:0] dst_reg,     dst_next;
	logic        ready_reg,   ready_next;
	logic        rwr_reg,     rwr_next;
	logic [3:0]  rsel_reg,    rsel_next;
	logic [7:0]  rdat_reg,    rdat_next;
	logic        done_reg,    done_next;
	logic        req_reg,     req_next;
	logic        we_reg,      we_next;
	logic [1:0]  size_reg,    size_next;
	logic [23:0] addr_reg,    addr_next;
	logic [31:0] wdat_reg,    wdat_next;
	logic        taken_reg,   taken_next;
	logic        trap_reg,    trap_next;

	////////////////////////////////////////////////////////////////////////////////
	// Decode of the current word
	wire logic        idle_st  = (state_reg == S_IDLE);
	wire logic        take     = instr_valid_in & ready_reg;
	wire logic [15:0] cw       = idle_st ? instr_word_in : iw_reg;
	wire logic [31:0] cx       = idle_st ? instr_ext_in : ext_reg;
	wire logic [3:0]  opf      = cw[OPF_LSB +: 4];
	wire logic [3:0]  sub      = cw[SUB_LSB +: 4];
	wire logic [2:0]  bit_no   = cw[BITNO_LSB +: 3];
	wire logic        sel_mem  = cw[MEMSEL_BIT];
	wire logic        sel_exr  = cw[MEMSEL_BIT];
	wire logic [1:0]  mode     = cw[MODE_LSB +: 2];
	wire logic [23:0] seq_pc   = pc_reg + 24'({instr_len_in, 1'b0});
	wire logic [23:0] br_tgt   = seq_pc + {{16{cw[7]}}, cw[7:0]};
	wire logic [23:0] rel_tgt  = seq_pc + {{8{cx[15]}}, cx[15:0]};
	wire logic [23:0] vec_addr = TRAP_VEC_BASE + 24'({cw[TRAPNO_LSB +: 2], 2'b00});
	wire logic [7:0]  bit_src  = idle_st ? reg_byte_in : mem_rdata_in[7:0];
	wire logic [7:0]  bit_mask = 8'h01 << bit_no;
	wire logic [7:0]  ctl_cur  = sel_exr ? exr_reg : ccr_reg;
	wire logic [7:0]  ctl_src  = idle_st ? (mode == MODE_IMM ? cx[7:0] : reg_byte_in)
	                                     : mem_rdata_in[15:8];
	wire logic        copy_b   = (sub == SUB_COPY_BYTE);
	wire logic        cnt_zero = copy_b ? (count_word_in[7:0] == 8'h00)
	                                    : (count_word_in == 16'h0000);
	wire logic        cnt_last = copy_b ? (cnt_reg[7:0] == 8'h01) : (cnt_reg == 16'h0001);
	wire logic [15:0] cnt_dec  = copy_b ? {cnt_reg[15:8], cnt_reg[7:0] - 8'h01}
	                                    : cnt_reg - 16'h0001;
	wire logic        is_store = (sub == SUB_FLAG_TO_BIT) | (sub == SUB_INV_FLAG_TO_BIT);

	// Returns {new carry, new operand byte}
	function automatic logic [8:0] bit_exec(input logic [3:0] op, input logic [2:0] idx,
	                                        input logic [7:0] opnd, input logic c);
		logic b;
		logic [7:0] res;
		b   = opnd[idx];
		res = opnd;
		case (op)
			SUB_CARRY_XOR_BIT:     bit_exec = {c ^ b, opnd};
			SUB_CARRY_XOR_INV_BIT: bit_exec = {c ^ ~b, opnd};
			SUB_BIT_TO_FLAG:       bit_exec = {b, opnd};
			SUB_INV_BIT_TO_FLAG:   bit_exec = {~b, opnd};
			SUB_FLAG_TO_BIT: begin
				res[idx] = c;
				bit_exec = {c, res};
			end
			SUB_INV_FLAG_TO_BIT: begin
				res[idx] = ~c;
				bit_exec = {c, res};
			end
			default:               bit_exec = {c, opnd};
		endcase
	endfunction

	function automatic logic [7:0] ctl_exec(input logic [3:0] op, input logic [7:0] cur,
	                                        input logic [7:0] src);
		case (op)
			SUB_AND_CTL: ctl_exec = cur & src;
			SUB_OR_CTL:  ctl_exec = cur | src;
			SUB_XOR_CTL: ctl_exec = cur ^ src;
			default:     ctl_exec = src;
		endcase
	endfunction

	wire logic [8:0] bit_res = bit_exec(sub, bit_no, bit_src, ccr_reg[CCR_C]);
	wire logic [7:0] ctl_res = ctl_exec(sub, ctl_cur, ctl_src);

	////////////////////////////////////////////////////////////////////////////////
	// Branch condition
	cond_if cif ();
	assign cif.cc = cw[SUB_LSB +: 4];
	assign cif.c  = ccr_reg[CCR_C];
	assign cif.z  = ccr_reg[CCR_Z];
	assign cif.v  = ccr_reg[CCR_V];
	assign cif.n  = ccr_reg[CCR_N];

	branch_cond_eval u_cond (
		.bus (cif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing
	always_comb begin
		state_next = state_reg;
		iw_next    = iw_reg;
		ext_next   = ext_reg;
		pc_next    = pc_reg;
		sp_next    = sp_reg;
		ccr_next   = ccr_reg;
		exr_next   = exr_reg;
		cnt_next   = cnt_reg;
		src_next   = src_reg;
		dst_next   = dst_reg;
		rwr_next   = 1'b0;
		rsel_next  = rsel_reg;
		rdat_next  = rdat_reg;
		done_next  = 1'b0;
		taken_next = 1'b0;
		trap_next  = 1'b0;
		req_next   = req_reg & ~mem_ack_in;
		we_next    = we_reg;
		size_next  = size_reg;
		addr_next  = addr_reg;
		wdat_next  = wdat_reg;
		case (state_reg)
			S_IDLE: if (take) begin
				iw_next   = instr_word_in;
				ext_next  = instr_ext_in;
				pc_next   = seq_pc;
				rsel_next = cw[REGSEL_LSB +: 4];
				case (opf)
					OPF_BRANCH: if (cif.take) begin
						pc_next    = br_tgt;
						taken_next = 1'b1;
					end
					OPF_BIT: if (sel_mem) begin
						{req_next, we_next, size_next, addr_next} = {2'b10, SZ_BYTE, cx[23:0]};
						state_next = S_BIT_RD;
					end else begin
						ccr_next[CCR_C] = bit_res[8];
						rwr_next        = is_store;
						rdat_next       = bit_res[7:0];
					end
					OPF_JUMP: case (sub)
						SUB_UNCOND_JUMP: pc_next = cx[23:0];
						SUB_ABS_CALL, SUB_REL_CALL: begin
							pc_next    = (sub == SUB_ABS_CALL) ? cx[23:0] : rel_tgt;
							sp_next    = sp_reg - STACK_STEP;
							{req_next, we_next, size_next} = {2'b11, SZ_LONG};
							addr_next  = sp_reg - STACK_STEP;
							wdat_next  = {8'h00, seq_pc};
							state_next = S_PUSH;
						end
						SUB_SUB_RETURN: begin
							{req_next, we_next, size_next, addr_next} = {2'b10, SZ_LONG, sp_reg};
							state_next = S_POP;
						end
						default: ;
					endcase
					OPF_SYS: case (sub)
						SUB_SLEEP: state_next = S_SLEEP;
						SUB_EXC_RETURN: begin
							{req_next, we_next, size_next, addr_next} = {2'b10, SZ_LONG, sp_reg};
							state_next = S_POP;
						end
						SUB_SW_TRAP: begin
							trap_next  = 1'b1;
							sp_next    = sp_reg - STACK_STEP;
							{req_next, we_next, size_next} = {2'b11, SZ_LONG};
							addr_next  = sp_reg - STACK_STEP;
							wdat_next  = {ccr_reg, seq_pc};
							state_next = S_PUSH;
						end
						SUB_LOAD_CTL, SUB_AND_CTL, SUB_OR_CTL, SUB_XOR_CTL:
							if (sub == SUB_LOAD_CTL && mode == MODE_MEM) begin
								{req_next, we_next, size_next, addr_next} =
									{2'b10, SZ_WORD, cx[23:0]};
								state_next = S_CTL_RD;
							end else if (sel_exr) begin
								exr_next = ctl_res;
							end else begin
								ccr_next = ctl_res;
							end
						SUB_STORE_CTL: if (mode == MODE_MEM) begin
							{req_next, we_next, size_next, addr_next} = {2'b11, SZ_WORD, cx[23:0]};
							wdat_next  = {16'h0000, ctl_cur, 8'h00};
							state_next = S_CTL_WR;
						end else begin
							rwr_next  = 1'b1;
							rdat_next = ctl_cur;
						end
						SUB_COPY_BYTE, SUB_COPY_WORD: begin
							cnt_next = count_word_in;
							src_next = src_ptr_in;
							dst_next = dst_ptr_in;
							if (cnt_zero) begin
								done_next = 1'b1;
							end else begin
								{req_next, we_next, size_next, addr_next} =
									{2'b10, SZ_BYTE, src_ptr_in};
								state_next = S_COPY_RD;
							end
						end
						default: ;  // Idle and unknown codes only advance the counter
					endcase
					default: ;
				endcase
			end
			S_BIT_RD: if (mem_ack_in) begin
				ccr_next[CCR_C] = bit_res[8];
				if (is_store) begin
					{req_next, we_next} = 2'b11;
					wdat_next  = {24'h000000, bit_res[7:0]};
					state_next = S_BIT_WR;
				end else begin
					state_next = S_IDLE;
				end
			end
			S_CTL_RD: if (mem_ack_in) begin
				if (sel_exr)
					exr_next = ctl_res;
				else
					ccr_next = ctl_res;
				state_next = S_IDLE;
			end
			S_PUSH: if (mem_ack_in) begin
				if (opf == OPF_SYS) begin
					{req_next, we_next, addr_next} = {2'b10, vec_addr};
					state_next = S_VEC;
				end else begin
					state_next = S_IDLE;
				end
			end
			S_VEC: if (mem_ack_in) begin
				pc_next         = mem_rdata_in[23:0];
				ccr_next[CCR_I] = 1'b1;
				state_next      = S_IDLE;
			end
			S_POP: if (mem_ack_in) begin
				pc_next = mem_rdata_in[23:0];
				sp_next = sp_reg + STACK_STEP;
				if (opf == OPF_SYS)
					ccr_next = mem_rdata_in[31:24];
				state_next = S_IDLE;
			end
			S_COPY_RD: if (mem_ack_in) begin
				{req_next, we_next, addr_next} = {2'b11, dst_reg};
				wdat_next  = {24'h000000, mem_rdata_in[7:0]};
				state_next = S_COPY_WR;
			end
			S_COPY_WR: if (mem_ack_in) begin
				src_next = src_reg + PTR_STEP;
				dst_next = dst_reg + PTR_STEP;
				cnt_next = cnt_dec;
				if (cnt_last) begin
					done_next  = 1'b1;
					state_next = S_IDLE;
				end else begin
					{req_next, we_next, addr_next} = {2'b10, src_reg + PTR_STEP};
					state_next = S_COPY_RD;
				end
			end
			S_BIT_WR, S_CTL_WR: if (mem_ack_in)
				state_next = S_IDLE;
			S_SLEEP: if (wake_in)
				state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
		// The next instruction is taken as soon as the unit returns to idle
		ready_next = (state_next == S_IDLE);
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_reg <= S_IDLE;
			{iw_reg, ext_reg, cnt_reg, src_reg, dst_reg} <= '0;
			{pc_reg, sp_reg, ccr_reg, exr_reg} <= {PC_RESET, SP_RESET, CCR_RESET, EXR_RESET};
			{ready_reg, rwr_reg, rsel_reg, rdat_reg, done_reg} <= '0;
			{req_reg, we_reg, size_reg, addr_reg, wdat_reg, taken_reg, trap_reg} <= '0;
		end else begin
			state_reg <= state_next;
			{iw_reg, ext_reg, cnt_reg, src_reg, dst_reg} <=
				{iw_next, ext_next, cnt_next, src_next, dst_next};
			{pc_reg, sp_reg, ccr_reg, exr_reg} <= {pc_next, sp_next, ccr_next, exr_next};
			{ready_reg, rwr_reg, rsel_reg, rdat_reg, done_reg} <=
				{ready_next, rwr_next, rsel_next, rdat_next, done_next};
			{req_reg, we_reg, size_reg, addr_reg, wdat_reg, taken_reg, trap_reg} <=
				{req_next, we_next, size_next, addr_next, wdat_next, taken_next, trap_next};
		end
	end

	// Sleep is a flop of its own so the output never glitches on decode
	logic sleep_reg;
	always_ff @(posedge clk_in) begin
		if (!resetn_in)
			sleep_reg <= 1'b0;
		else
			sleep_reg <= (state_next == S_SLEEP);
	end

	assign instr_ready_out  = ready_reg;
	assign reg_wr_out       = rwr_reg;
	assign reg_wr_sel_out   = rsel_reg;
	assign reg_wr_data_out  = rdat_reg;
	assign count_word_out   = cnt_reg;
	assign src_ptr_out      = src_reg;
	assign dst_ptr_out      = dst_reg;
	assign copy_done_out    = done_reg;
	assign mem_req_out      = req_reg;
	assign mem_we_out       = we_reg;
	assign mem_size_out     = size_reg;
	assign mem_addr_out     = addr_reg;
	assign mem_wdata_out    = wdat_reg;
	assign pc_out           = pc_reg;
	assign ccr_out          = ccr_reg;
	assign exr_out          = exr_reg;
	assign sp_out           = sp_reg;
	assign sleep_out        = sleep_reg;
	assign branch_taken_out = taken_reg;
	assign trap_out         = trap_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	wire logic sel_bit = reg_byte_in[bit_no];
	wire logic reg_bit = idle_st && take && opf == OPF_BIT && !sel_mem;

	chk_xor_carry: assert property (reg_bit && sub == SUB_CARRY_XOR_BIT |=>
		ccr_reg[CCR_C] == ($past(ccr_reg[CCR_C]) ^ $past(sel_bit)))
		else $error("carry xor bit wrong");
	chk_inv_load: assert property (reg_bit && sub == SUB_INV_BIT_TO_FLAG |=>
		ccr_reg[CCR_C] == !$past(sel_bit))
		else $error("inverted bit load wrong");
	chk_bit_store: assert property (reg_bit && sub == SUB_FLAG_TO_BIT |=>
		reg_wr_out && ((reg_wr_data_out ^ $past(reg_byte_in)) & ~$past(bit_mask)) == 8'h00
		&& ((reg_wr_data_out & $past(bit_mask)) != 8'h00) == $past(ccr_reg[CCR_C]))
		else $error("bit store disturbed operand");
	chk_branch_equal: assert property (take && opf == OPF_BRANCH && sub == 4'h7 |=>
		branch_taken_out == $past(ccr_reg[CCR_Z]))
		else $error("equal branch decision wrong");
	chk_branch_higher: assert property (take && opf == OPF_BRANCH && sub == 4'h2 |=>
		branch_taken_out == !$past(ccr_reg[CCR_C] | ccr_reg[CCR_Z]))
		else $error("higher branch decision wrong");
	chk_idle_advance: assert property (take && instr_word_in == 16'h0000 &&
		instr_len_in == 2'h1 |=> pc_reg == $past(pc_reg) + 24'h000002
		&& ccr_reg == $past(ccr_reg) && !mem_req_out)
		else $error("idle instruction changed state");
	chk_and_ctl: assert property (take && opf == OPF_SYS && sub == SUB_AND_CTL && !sel_exr |=>
		ccr_reg == ($past(ccr_reg) & $past(instr_ext_in[7:0])))
		else $error("control and wrong");
	chk_copy_zero: assert property (take && opf == OPF_SYS && copy_b && cnt_zero |=>
		copy_done_out && !mem_req_out && instr_ready_out)
		else $error("zero count copy moved data");

	sequence copy_read_ack;
		state_reg == S_COPY_RD && mem_ack_in;
	endsequence
	sequence copy_write_issue;
		mem_req_out && mem_we_out && mem_addr_out == dst_reg;
	endsequence
	chk_copy_pair: assert property (copy_read_ack |=> copy_write_issue
		and mem_wdata_out[7:0] == $past(mem_rdata_in[7:0]))
		else $error("copy write not paired to read");
	chk_call_push: assert property (take && opf == OPF_JUMP && sub == SUB_ABS_CALL |=>
		mem_req_out && mem_we_out && mem_addr_out == $past(sp_reg) - STACK_STEP
		&& mem_wdata_out[23:0] == $past(seq_pc))
		else $error("call did not push return address");
	chk_sleep_hold: assert property (sleep_out && !wake_in |=> sleep_out)
		else $error("left power-down without wake");
endmodule // cpu_bit_branch_control_ops
`default_nettype wire

/* hdl/cpu_ops_pkg.sv */
package cpu_ops_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction word field positions
	localparam int OPF_LSB    = 12;
	localparam int SUB_LSB    = 8;
	localparam int BITNO_LSB  = 4;
	localparam int MEMSEL_BIT = 7;
	localparam int MODE_LSB   = 5;
	localparam int REGSEL_LSB = 0;
	localparam int TRAPNO_LSB = 0;

	// Leading operation field values
	localparam logic [3:0] OPF_SYS    = 4'h0;
	localparam logic [3:0] OPF_BRANCH = 4'h4;
	localparam logic [3:0] OPF_JUMP   = 4'h5;
	localparam logic [3:0] OPF_BIT    = 4'h7;

	// Second operation field, bit transfer group
	localparam logic [3:0] SUB_CARRY_XOR_BIT     = 4'h0;
	localparam logic [3:0] SUB_CARRY_XOR_INV_BIT = 4'h1;
	localparam logic [3:0] SUB_BIT_TO_FLAG       = 4'h2;
	localparam logic [3:0] SUB_INV_BIT_TO_FLAG   = 4'h3;
	localparam logic [3:0] SUB_FLAG_TO_BIT       = 4'h4;
	localparam logic [3:0] SUB_INV_FLAG_TO_BIT   = 4'h5;

	// Second operation field, system group
	localparam logic [3:0] SUB_IDLE         = 4'h0;
	localparam logic [3:0] SUB_SLEEP        = 4'h1;
	localparam logic [3:0] SUB_EXC_RETURN   = 4'h2;
	localparam logic [3:0] SUB_SW_TRAP      = 4'h3;
	localparam logic [3:0] SUB_LOAD_CTL     = 4'h4;
	localparam logic [3:0] SUB_STORE_CTL    = 4'h5;
	localparam logic [3:0] SUB_AND_CTL      = 4'h6;
	localparam logic [3:0] SUB_OR_CTL       = 4'h7;
	localparam logic [3:0] SUB_XOR_CTL      = 4'h8;
	localparam logic [3:0] SUB_COPY_BYTE    = 4'h9;
	localparam logic [3:0] SUB_COPY_WORD    = 4'hA;

	// Second operation field, jump group
	localparam logic [3:0] SUB_UNCOND_JUMP  = 4'h0;
	localparam logic [3:0] SUB_ABS_CALL     = 4'h1;
	localparam logic [3:0] SUB_REL_CALL     = 4'h2;
	localparam logic [3:0] SUB_SUB_RETURN   = 4'h3;

	// Control register source and destination modes
	localparam logic [1:0] MODE_IMM = 2'h0;
	localparam logic [1:0] MODE_REG = 2'h1;
	localparam logic [1:0] MODE_MEM = 2'h2;

	// Condition code register bit positions
	localparam int CCR_I = 7;
	localparam int CCR_N = 3;
	localparam int CCR_Z = 2;
	localparam int CCR_V = 1;
	localparam int CCR_C = 0;

	// Memory access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// Values after reset, fixed addresses and pointer steps
	localparam logic [7:0]  CCR_RESET      = 8'h80;
	localparam logic [7:0]  EXR_RESET      = 8'h07;
	localparam logic [23:0] PC_RESET       = 24'h000100;
	localparam logic [23:0] SP_RESET       = 24'h00FFFC;
	localparam logic [23:0] TRAP_VEC_BASE  = 24'h000020;
	localparam logic [23:0] STACK_STEP     = 24'h000004;
	localparam logic [23:0] PTR_STEP       = 24'h000001;

	typedef enum logic [3:0] {
		S_IDLE    = 4'h0,
		S_BIT_RD  = 4'h1,
		S_BIT_WR  = 4'h2,
		S_CTL_RD  = 4'h3,
		S_CTL_WR  = 4'h4,
		S_PUSH    = 4'h5,
		S_VEC     = 4'h6,
		S_POP     = 4'h7,
		S_COPY_RD = 4'h8,
		S_COPY_WR = 4'h9,
		S_SLEEP   = 4'hA
	} state_e;

endpackage

/* hdl/cond_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
	logic [3:0] cc;
	logic       c;
	logic       z;
	logic       v;
	logic       n;
	logic       take;

	modport requester (output cc, c, z, v, n, input take);
	modport evaluator (input cc, c, z, v, n, output take);
endinterface
`default_nettype wire

/* hdl/branch_cond_eval.sv */
`timescale 1ns/1ps
`default_nettype none
module branch_cond_eval (
	// Condition and flags in, decision out
	cond_if.evaluator bus
);
	logic nv;
	logic take;

	assign nv = bus.n ^ bus.v;

	always_comb begin
		case (bus.cc)
			4'h0: take = 1'b1;
			4'h1: take = 1'b0;
			4'h2: take = ~(bus.c | bus.z);
			4'h3: take = bus.c | bus.z;
			4'h4: take = ~bus.c;
			4'h5: take = bus.c;
			4'h6: take = ~bus.z;
			4'h7: take = bus.z;
			4'h8: take = ~bus.v;
			4'h9: take = bus.v;
			4'hA: take = ~bus.n;
			4'hB: take = bus.n;
			4'hC: take = ~nv;
			4'hD: take = nv;
			4'hE: take = ~(bus.z | nv);
			4'hF: take = bus.z | nv;
			default: take = 1'b0;
		endcase
	end

	assign bus.take = take;
endmodule // branch_cond_eval
`default_nettype wire

/* testbench/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_model
	import cpu_ops_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// Bus from the core
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic [1:0]  size_in,
	input  wire logic [23:0] addr_in,
	input  wire logic [31:0] wdata_in,
	output logic             ack_out = 1'b0,
	output logic [31:0]      rdata_out = 32'h0
);
	logic [7:0]       m [0:255];
	logic [1:0]       wait_reg = 2'h0;
	wire logic [7:0]  a = addr_in[7:0];
	wire logic [31:0] l = {m[a], m[a + 8'h01], m[a + 8'h02], m[a + 8'h03]};
	initial for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'h5A;
	////////////////////////////////////////////////////////////////////////////////
	// Odd addresses answer at once, even ones stall so both paths get exercised
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		// Idle data lines never hold the last value
		rdata_out <= ~rdata_out;
		wait_reg <= 2'h0;
		if (resetn_in && req_in && !ack_out) begin
			if (a[0] || wait_reg == 2'h3) begin
				ack_out <= 1'b1;
				if (we_in && size_in == SZ_BYTE) m[a] <= wdata_in[7:0];
				if (we_in && size_in == SZ_WORD) {m[a], m[a + 8'h01]} <= wdata_in[15:0];
				if (we_in && size_in == SZ_LONG) {m[a], m[a + 8'h01], m[a + 8'h02], m[a + 8'h03]} <= wdata_in;
				if (!we_in) rdata_out <= (size_in == SZ_LONG) ? l : (size_in == SZ_WORD) ? {16'hC3C3, l[31:16]} : {24'hC3C3C3, l[31:24]};
			end else wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule // mem_model
`default_nettype wire

/* testbench/test_cpu_bit_branch_control_ops.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cpu_bit_branch_control_ops;
	import cpu_ops_pkg::*;
	logic clk_in = 0, resetn_in = 0, instr_valid_in = 0, wake_in = 0, mem_ack_in;
	logic instr_ready_out, reg_wr_out, copy_done_out, mem_req_out, mem_we_out, sleep_out, branch_taken_out, trap_out;
	logic [1:0] instr_len_in = 1, mem_size_out;
	logic [3:0] reg_wr_sel_out;
	logic [7:0] reg_byte_in = 0, reg_wr_data_out, ccr_out, exr_out, x, v;
	logic [15:0] instr_word_in = 0, count_word_in = 0, count_word_out;
	logic [23:0] src_ptr_in = 0, dst_ptr_in = 0, src_ptr_out, dst_ptr_out, mem_addr_out, pc_out, sp_out;
	logic [23:0] xpc = PC_RESET, r;
	logic [31:0] instr_ext_in = 0, mem_rdata_in, mem_wdata_out;
	int miscompares = 0, samples_checked = 0, dones = 0;
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) if (copy_done_out === 1'b1) dones++;
	cpu_bit_branch_control_ops dut (.clk_in, .resetn_in, .instr_valid_in, .instr_word_in, .instr_ext_in,
		.instr_len_in, .reg_byte_in, .instr_ready_out, .count_word_in, .src_ptr_in, .dst_ptr_in, .reg_wr_out,
		.reg_wr_sel_out, .reg_wr_data_out, .count_word_out, .src_ptr_out, .dst_ptr_out, .copy_done_out,
		.mem_req_out, .mem_we_out, .mem_size_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in,
		.wake_in, .pc_out, .ccr_out, .exr_out, .sp_out, .sleep_out, .branch_taken_out, .trap_out);
	mem_model mem (.clk_in, .resetn_in, .req_in(mem_req_out), .we_in(mem_we_out), .size_in(mem_size_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
	////////////////////////////////////////////////////////////////////////////////
	// Wide enough that packed pc, flags and stack pointer are compared whole
	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Offer one instruction and wait, bounded, until it is taken
	task issue(input logic [15:0] w, input logic [31:0] e, input logic [1:0] n, input logic [7:0] b);
		@(posedge clk_in);
		instr_valid_in <= 1'b1;
		instr_word_in <= w;
		instr_ext_in <= e;
		instr_len_in <= n;
		reg_byte_in <= b;
		@(posedge clk_in);
		for (int i = 0; i < 300 && instr_ready_out !== 1'b1; i++) @(posedge clk_in);
		instr_valid_in <= 1'b0;
		xpc = xpc + 24'(2 * n);
		#1;
	endtask
	function logic [15:0] ctl(input logic [3:0] s, input logic [7:0] md);
		return {OPF_SYS, s, md};
	endfunction
	function logic tk(input logic [3:0] cc, input logic [3:0] f);
		logic [7:0] p;
		p = {~(f[2] | (f[3] ^ f[1])), ~(f[3] ^ f[1]), ~f[3], ~f[1], ~f[2], ~f[0], ~(f[0] | f[2]), 1'b1};
		return p[cc[3:1]] ^ cc[0];
	endfunction
	// Block copy, then an idle instruction that can only be taken once the copy ends
	task cp(input logic [3:0] s, input logic [23:0] sa, input logic [23:0] da, input logic [15:0] c);
		logic [15:0] k;
		@(posedge clk_in);
		src_ptr_in <= sa;
		dst_ptr_in <= da;
		count_word_in <= c;
		k = (s == SUB_COPY_BYTE) ? {8'h00, c[7:0]} : c;
		issue(ctl(s, 8'h00), 0, 1, 0);
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check(count_word_out, (s == SUB_COPY_BYTE) ? {c[15:8], 8'h00} : 16'h0);
		check(src_ptr_out, sa + 24'(k));
		check(dst_ptr_out, da + 24'(k));
		for (int j = 0; j < 4; j++) check(mem.m[8'(da) + 8'(j)], 8'(j < k ? sa + j : da + j) ^ 8'h5A);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		#1;
		check({pc_out, ccr_out, exr_out}, {PC_RESET, CCR_RESET, EXR_RESET});
		issue(ctl(SUB_LOAD_CTL, 8'h00), 8'h0F, 2, 0);
		check(ccr_out, 8'h0F);
		issue(ctl(SUB_AND_CTL, 8'h00), 8'h3C, 2, 0);
		check(ccr_out, 8'h0C);
		issue(ctl(SUB_OR_CTL, 8'h00), 8'h81, 2, 0);
		check(ccr_out, 8'h8D);
		issue(ctl(SUB_XOR_CTL, 8'h80), 8'hFF, 2, 0);
		check(exr_out, 8'hF8);
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check(pc_out, xpc);
		for (int f = 0; f < 16; f++) begin
			issue(ctl(SUB_LOAD_CTL, 8'h00), f, 2, 0);
			for (int c = 0; c < 16; c++) begin
				issue({OPF_BRANCH, 4'(c), 8'h02}, 0, 1, 0);
				check(branch_taken_out, tk(4'(c), 4'(f)));
				xpc = xpc + (tk(4'(c), 4'(f)) ? 24'h2 : 24'h0);
				check(pc_out, xpc);
			end
		end
		for (int n = 0; n < 192; n++) begin
			issue(ctl(SUB_LOAD_CTL, 8'h00), n[0], 2, 0);
			issue({OPF_BIT, 4'(n / 32), 1'b0, 3'(n / 2), 4'h3}, 0, 1, 8'hA5);
			x = 8'hA5;
			x[3'(n / 2)] = (n < 160) ? n[0] : ~n[0];
			if (n < 128)
				check(ccr_out[0],
					(n < 64 && n[0]) ^ (8'hA5 >> (n / 2 % 8) & 1) ^ (n / 32 % 2));
			else
				check({reg_wr_out, reg_wr_sel_out, reg_wr_data_out}, {1'b1, 4'h3, x});
		end
		issue(ctl(SUB_LOAD_CTL, 8'h40), 32'h20, 2, 0);
		issue(ctl(SUB_STORE_CTL, 8'h40), 32'h31, 2, 0);
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check(ccr_out, 8'h7A);
		check({mem.m[8'h31], mem.m[8'h32]}, 16'h7A00);
		cp(SUB_COPY_BYTE, 24'h10, 24'h80, 16'h1203);
		cp(SUB_COPY_WORD, 24'h41, 24'h90, 16'h0002);
		cp(SUB_COPY_BYTE, 24'h50, 24'hA0, 16'h0100);
		check(dones, 3);
		issue({OPF_SYS, SUB_STORE_CTL, 8'h23}, 0, 1, 0);
		check({reg_wr_out, reg_wr_sel_out, reg_wr_data_out}, {1'b1, 4'h3, 8'h7A});
		issue(ctl(SUB_LOAD_CTL, 8'h00), 8'h05, 2, 0);
		issue({OPF_SYS, SUB_SW_TRAP, 8'h01}, 0, 1, 0);
		check({trap_out, sp_out}, {1'b1, SP_RESET - STACK_STEP});
		r = xpc;
		v = 8'(TRAP_VEC_BASE) + 8'h04;
		xpc = {mem.m[v + 8'h01], mem.m[v + 8'h02], mem.m[v + 8'h03]};
		issue(ctl(SUB_EXC_RETURN, 8'h00), 0, 1, 0);
		check({pc_out, ccr_out}, {xpc, 8'h85});
		v = 8'(SP_RESET - STACK_STEP);
		check({mem.m[v], mem.m[v + 8'h01], mem.m[v + 8'h02], mem.m[v + 8'h03]}, {8'h05, r});
		xpc = r;
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check({pc_out, ccr_out, sp_out}, {xpc, 8'h05, SP_RESET});
		issue({OPF_JUMP, SUB_ABS_CALL, 8'h00}, 32'h000400, 3, 0);
		r = xpc;
		xpc = 24'h000400;
		issue({OPF_JUMP, SUB_SUB_RETURN, 8'h00}, 0, 1, 0);
		check({pc_out, mem.m[v + 8'h01], mem.m[v + 8'h02], mem.m[v + 8'h03]}, {xpc, r});
		xpc = r;
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check({pc_out, sp_out}, {xpc, SP_RESET});
		// Carry is set here, so the memory bit store must raise bit 2 only
		x = mem.m[8'h61];
		x[2] = 1'b1;
		issue({OPF_BIT, SUB_FLAG_TO_BIT, 8'hA0}, 32'h61, 2, 0);
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check(mem.m[8'h61], x);
		issue(ctl(SUB_SLEEP, 8'h00), 0, 1, 0);
		check({sleep_out, instr_ready_out}, 2'b10);
		@(posedge clk_in) wake_in <= 1'b1;
		issue(ctl(SUB_IDLE, 8'h00), 0, 1, 0);
		check(sleep_out, 1'b0);
		stop_test;
	end
	initial begin
		#200000;
		miscompares++;
		stop_test;
	end
endmodule // test_cpu_bit_branch_control_ops
`default_nettype wire
